// ==== design/ivnc_top.sv ====
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`include "ivnc_params.svh"

module ivnc_top #(
  parameter int unsigned NMI_SYNC_STAGES = 2,
  parameter int unsigned EXT_SYNC_STAGES = 2
) (
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral event pulses, on pclk.
  input wire logic timer_overflow_event,
  input wire logic watchdog_interval_event,
  input wire logic bus_compare_match_event,
  input wire logic divider_fault_event,
  input wire logic [1:0] dma_end_event,
  // Non-maskable interrupt pin.
  input wire logic nmi_pin,
  // External vector pins.
  input wire logic [15:0] ext_vector,
  // CPU acknowledge and returned vector.
  input wire logic cpu_ack,
  input wire logic [2:0] cpu_ack_src,
  output logic [15:0] vector_out,
  output logic vector_valid,
  // Requests towards the CPU.
  output logic irq,
  output logic nmi_request,
  output logic [3:0] watchdog_priority,
  output logic [3:0] buscmp_priority
);

  // ************************************************************
  // Elaboration checks.
  // ************************************************************

  // The external vector pins need a real synchroniser too.
  initial begin
    if (EXT_SYNC_STAGES < 2) begin
      $error("ivnc_top needs at least two stages on the external vector");
    end
  end

  // ************************************************************
  // Storage.
  // ************************************************************

  logic [6:0] timer_overflow_vector_field; // Timer overflow vector.
  logic [6:0] watchdog_interval_vector_field; // Watchdog interval vector.
  logic [6:0] buscmp_vector_field; // Bus compare match vector.
  logic [15:0] divider_fault_vector; // Divider overflow/underflow vector.
  logic [7:0] dma_end_vector_field [2]; // One vector per DMA channel.
  logic nmi_edge_select; // One selects the rising edge.
  logic vector_mode_select; // One selects external vectors.
  logic [3:0] watchdog_priority_field; // Shared watchdog and bus level.
  logic [6:0] int_status; // Sticky event bits.
  logic [6:0] int_mask; // One lets a status bit reach irq.
  logic nmi_pin_level; // Synchronised pin level.
  logic nmi_edge; // One pulse per qualifying edge.
  logic [15:0] ext_sync [EXT_SYNC_STAGES]; // External vector synchroniser.
  logic [6:0] events; // All event pulses gathered.

  // Access strobes of the APB access phase.
  logic wr_en;
  logic rd_en;
  logic addr_hit;

  // ************************************************************
  // Helper functions.
  // ************************************************************

  // Merges write data into an old word under the byte strobes.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0] strb);
    logic [31:0] result;
    result = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        result[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return result;
  endfunction

  // Places a seven-bit field into the upper byte of a halfword.
  function automatic logic [31:0] hi_field(input logic [6:0] v);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`IVNC_HI_FIELD_MSB:`IVNC_HI_FIELD_LSB] = v;
    return w;
  endfunction

  // Word presently read at an address, used for reads and merges.
  function automatic logic [31:0] reg_word(input logic [31:0] addr);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (addr)
      `IVNC_ADDR_TIMER_VEC: begin
        w = hi_field(timer_overflow_vector_field);
      end
      `IVNC_ADDR_WDT_BCM_VEC: begin
        w = hi_field(watchdog_interval_vector_field);
        w[`IVNC_LO_FIELD_MSB:`IVNC_LO_FIELD_LSB] = buscmp_vector_field;
      end
      `IVNC_ADDR_DIV_VEC: begin
        w[`IVNC_DIV_FIELD_MSB:0] = divider_fault_vector;
      end
      `IVNC_ADDR_DMA0_VEC: begin
        w[`IVNC_DMA_FIELD_MSB:0] = dma_end_vector_field[0];
      end
      `IVNC_ADDR_DMA1_VEC: begin
        w[`IVNC_DMA_FIELD_MSB:0] = dma_end_vector_field[1];
      end
      `IVNC_ADDR_INT_CTRL: begin
        w[`IVNC_NMI_LEVEL_BIT] = nmi_pin_level;
        w[`IVNC_NMI_EDGE_BIT] = nmi_edge_select;
        w[`IVNC_VEC_MODE_BIT] = vector_mode_select;
      end
      `IVNC_ADDR_PRIORITY: begin
        w[`IVNC_WDT_PRIO_MSB:`IVNC_WDT_PRIO_LSB] = watchdog_priority_field;
      end
      `IVNC_ADDR_INT_STATUS: begin
        w[6:0] = int_status;
      end
      `IVNC_ADDR_INT_MASK: begin
        w[6:0] = int_mask;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // True for every mapped address.
  function automatic logic is_mapped(input logic [31:0] addr);
    return addr == `IVNC_ADDR_TIMER_VEC || addr == `IVNC_ADDR_WDT_BCM_VEC ||
           addr == `IVNC_ADDR_DIV_VEC || addr == `IVNC_ADDR_DMA0_VEC ||
           addr == `IVNC_ADDR_DMA1_VEC || addr == `IVNC_ADDR_INT_CTRL ||
           addr == `IVNC_ADDR_PRIORITY || addr == `IVNC_ADDR_INT_STATUS ||
           addr == `IVNC_ADDR_INT_MASK;
  endfunction

  // ************************************************************
  // APB slave.
  // ************************************************************

  // The slave never stalls, so every access ends in its first access cycle.
  assign pready = 1'b1;
  assign addr_hit = is_mapped(paddr);
  assign wr_en = psel & penable & pwrite & addr_hit;
  assign rd_en = psel & penable & ~pwrite;
  // An unmapped address answers with an error and changes nothing.
  assign pslverr = psel & penable & ~addr_hit;
  // Read data is combinational from the register flip-flops.
  assign prdata = rd_en ? reg_word(paddr) : 32'h0000_0000;

  // Merged write word for the addressed register.
  logic [31:0] next_word;
  assign next_word = merge_bytes(reg_word(paddr), pwdata, pstrb);

  // ************************************************************
  // Vector number registers.
  // ************************************************************

  // Timer overflow vector; bit 15 and the low byte read zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_overflow_vector_field <= `IVNC_RST_VEC7;
    end else if (wr_en && paddr == `IVNC_ADDR_TIMER_VEC) begin
      timer_overflow_vector_field <= next_word[`IVNC_HI_FIELD_MSB:`IVNC_HI_FIELD_LSB];
    end
  end

  // Watchdog interval and bus compare match vectors share one register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_interval_vector_field <= `IVNC_RST_VEC7;
      buscmp_vector_field <= `IVNC_RST_VEC7;
    end else if (wr_en && paddr == `IVNC_ADDR_WDT_BCM_VEC) begin
      watchdog_interval_vector_field <= next_word[`IVNC_HI_FIELD_MSB:`IVNC_HI_FIELD_LSB];
      buscmp_vector_field <= next_word[`IVNC_LO_FIELD_MSB:`IVNC_LO_FIELD_LSB];
    end
  end

  // Divider vector; the upper half-word is not stored and reads zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider_fault_vector <= `IVNC_RST_VEC16;
    end else if (wr_en && paddr == `IVNC_ADDR_DIV_VEC) begin
      divider_fault_vector <= next_word[`IVNC_DIV_FIELD_MSB:0];
    end
  end

  // DMA end-of-transfer vectors, one byte per channel.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_end_vector_field[0] <= `IVNC_RST_VEC8;
      dma_end_vector_field[1] <= `IVNC_RST_VEC8;
    end else if (wr_en && paddr == `IVNC_ADDR_DMA0_VEC) begin
      dma_end_vector_field[0] <= next_word[`IVNC_DMA_FIELD_MSB:0];
    end else if (wr_en && paddr == `IVNC_ADDR_DMA1_VEC) begin
      dma_end_vector_field[1] <= next_word[`IVNC_DMA_FIELD_MSB:0];
    end
  end

  // ************************************************************
  // Interrupt control and priority.
  // ************************************************************

  // Edge select and vector mode; the level bit is read-only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_edge_select <= 1'b0;
      vector_mode_select <= 1'b0;
    end else if (wr_en && paddr == `IVNC_ADDR_INT_CTRL) begin
      nmi_edge_select <= next_word[`IVNC_NMI_EDGE_BIT];
      vector_mode_select <= next_word[`IVNC_VEC_MODE_BIT];
    end
  end

  // Watchdog priority field.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_priority_field <= `IVNC_RST_PRIO;
    end else if (wr_en && paddr == `IVNC_ADDR_PRIORITY) begin
      watchdog_priority_field <= next_word[`IVNC_WDT_PRIO_MSB:`IVNC_WDT_PRIO_LSB];
    end
  end

  // One field serves both sources, so they can never be told apart in rank.
  assign watchdog_priority = watchdog_priority_field;
  assign buscmp_priority = watchdog_priority_field;

  // ************************************************************
  // Non-maskable interrupt pin.
  // ************************************************************

  // Synchroniser and edge detector.
  ivnc_nmi_edge #(
    .SYNC_STAGES(NMI_SYNC_STAGES)
  ) u_nmi_edge (
    .pclk(pclk),
    .presetn(presetn),
    .nmi_pin(nmi_pin),
    .edge_rising(nmi_edge_select),
    .level(nmi_pin_level),
    .edge_pulse(nmi_edge)
  );

  // The request towards the CPU is one cycle per edge.
  assign nmi_request = nmi_edge;

  // ************************************************************
  // Event status, mask and interrupt line.
  // ************************************************************

  assign events = {nmi_edge, dma_end_event, divider_fault_event,
                   bus_compare_match_event, watchdog_interval_event,
                   timer_overflow_event};

  // Write-one-to-clear; an event in the clearing cycle still sets its bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= `IVNC_RST_EVENTS;
    end else begin
      int_status <= next_status();
    end
  end

  // Mask register, one bit per source.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask <= `IVNC_RST_EVENTS;
    end else if (wr_en && paddr == `IVNC_ADDR_INT_MASK) begin
      int_mask <= next_word[6:0];
    end
  end

  // Level output, high while any unmasked status bit is set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status() & int_mask);
    end
  end

  // Status after this edge, so irq follows it; only a strobed low byte clears.
  function automatic logic [6:0] next_status();
    logic [6:0] clr;
    clr = (wr_en && paddr == `IVNC_ADDR_INT_STATUS) ? pwdata[6:0] & {7{pstrb[0]}} : 7'h00;
    return (int_status & ~clr) | events;
  endfunction

  // ************************************************************
  // Vector return on acknowledge.
  // ************************************************************

  // External vector pins pass a synchroniser; the source must hold them
  // steady around the acknowledge, since bits are not sampled together.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < EXT_SYNC_STAGES; i++) begin
        ext_sync[i] <= `IVNC_RST_VEC16;
      end
    end else begin
      ext_sync[0] <= ext_vector;
      for (int i = 1; i < EXT_SYNC_STAGES; i++) begin
        ext_sync[i] <= ext_sync[i-1];
      end
    end
  end

  // Programmed vector of an acknowledged source.
  function automatic logic [15:0] auto_vector(input logic [2:0] src);
    logic [15:0] v;
    v = 16'h0000;
    unique case (src)
      ivnc_pkg::ivnc_src_timer: v = {9'h000, timer_overflow_vector_field};
      ivnc_pkg::ivnc_src_wdt: v = {9'h000, watchdog_interval_vector_field};
      ivnc_pkg::ivnc_src_bcm: v = {9'h000, buscmp_vector_field};
      ivnc_pkg::ivnc_src_div: v = divider_fault_vector;
      ivnc_pkg::ivnc_src_dma0: v = {8'h00, dma_end_vector_field[0]};
      ivnc_pkg::ivnc_src_dma1: v = {8'h00, dma_end_vector_field[1]};
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // The vector appears one cycle after the acknowledge; valid stays high as many cycles as the acknowledge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_out <= `IVNC_RST_VEC16;
      vector_valid <= 1'b0;
    end else begin
      vector_valid <= cpu_ack;
      if (cpu_ack) begin
        if (vector_mode_select) begin
          vector_out <= ext_sync[EXT_SYNC_STAGES-1];
        end else begin
          vector_out <= auto_vector(cpu_ack_src);
        end
      end
    end
  end

endmodule

// ==== design/ivnc_params.svh ====
`ifndef IVNC_PARAMS_SVH
`define IVNC_PARAMS_SVH

// ************************************************************
// Register byte addresses on the APB bus.
// ************************************************************
`define IVNC_ADDR_WDT_BCM_VEC 32'hfffffee4
`define IVNC_ADDR_DMA0_VEC 32'hffffffa0
`define IVNC_ADDR_DMA1_VEC 32'hffffffa8
`define IVNC_ADDR_TIMER_VEC 32'hfffffe68
`define IVNC_ADDR_DIV_VEC 32'hffffff0c
`define IVNC_ADDR_INT_CTRL 32'hffffffe0
`define IVNC_ADDR_PRIORITY 32'hffffffb8
`define IVNC_ADDR_INT_STATUS 32'hffffffb0
`define IVNC_ADDR_INT_MASK 32'hffffffb4

// ************************************************************
// Field positions.
// ************************************************************
`define IVNC_HI_FIELD_MSB 14
`define IVNC_HI_FIELD_LSB 8
`define IVNC_LO_FIELD_MSB 6
`define IVNC_LO_FIELD_LSB 0
`define IVNC_DIV_FIELD_MSB 15
`define IVNC_DMA_FIELD_MSB 7
`define IVNC_NMI_LEVEL_BIT 15
`define IVNC_NMI_EDGE_BIT 8
`define IVNC_VEC_MODE_BIT 0
`define IVNC_WDT_PRIO_MSB 7
`define IVNC_WDT_PRIO_LSB 4

// ************************************************************
// Reset values.
// ************************************************************
`define IVNC_RST_VEC7 7'h00
`define IVNC_RST_VEC8 8'h00
`define IVNC_RST_VEC16 16'h0000
`define IVNC_RST_PRIO 4'h0
`define IVNC_RST_EVENTS 7'h00

`endif

// ==== design/ivnc_pkg.sv ====
package ivnc_pkg;

  // Interrupt sources, in the order of their status and mask bits.
  typedef enum logic [2:0] {
    ivnc_src_timer,
    ivnc_src_wdt,
    ivnc_src_bcm,
    ivnc_src_div,
    ivnc_src_dma0,
    ivnc_src_dma1,
    ivnc_src_nmi
  } ivnc_src_e;

  // Number of event sources.
  localparam int unsigned IVNC_NUM_SRC = 7;

  // Width of a returned vector number.
  typedef logic [15:0] ivnc_vec_t;

endpackage

// ==== design/ivnc_nmi_edge.sv ====
`timescale 1ns/10ps

// Synchronises the non-maskable interrupt pin and detects the selected edge.
module ivnc_nmi_edge #(
  parameter int unsigned SYNC_STAGES = 2
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Pin and edge choice.
  input wire logic nmi_pin,
  input wire logic edge_rising,
  // Results.
  output logic level,
  output logic edge_pulse
);

  // Fewer than two stages would let a metastable value into logic.
  initial begin
    if (SYNC_STAGES < 2) begin
      $error("ivnc_nmi_edge needs at least two synchroniser stages");
    end
  end

  // Synchroniser chain; only the last stage is read by logic.
  logic [SYNC_STAGES-1:0] sync_chain;
  // Previous synchronised level, for edge detection.
  logic last_level;

  // The pin passes the chain before anything looks at it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_chain <= '0;
    end else begin
      sync_chain <= {sync_chain[SYNC_STAGES-2:0], nmi_pin};
    end
  end

  assign level = sync_chain[SYNC_STAGES-1];

  // Keep the previous level to compare against.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_level <= 1'b0;
    end else begin
      last_level <= level;
    end
  end

  // One pulse for each qualifying edge, rising or falling as chosen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_pulse <= 1'b0;
    end else if (edge_rising) begin
      edge_pulse <= level & ~last_level;
    end else begin
      edge_pulse <= ~level & last_level;
    end
  end

endmodule

// ==== tb/ivnc_props.sv ====
`timescale 1ns/10ps
`include "ivnc_params.svh"
// ************************************************************
// Port checks for the vector and pin block.
// ************************************************************
module ivnc_props #(
  parameter int unsigned NMI_SYNC_STAGES = 2,
  parameter int unsigned EXT_SYNC_STAGES = 2
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bus side.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  // Pin, acknowledge and requests.
  input wire logic nmi_pin,
  input wire logic cpu_ack,
  input wire logic vector_valid,
  input wire logic nmi_request,
  input wire logic [3:0] watchdog_priority,
  input wire logic [3:0] buscmp_priority
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles since the pin last moved; it saturates so a quiet pin never wraps.
  logic [3:0] quiet;
  logic pin_q;
  // Track pin movement, so level checks wait out the synchroniser.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet <= 4'h0;
      pin_q <= 1'b0;
    end else begin
      pin_q <= nmi_pin;
      if (nmi_pin != pin_q) begin
        quiet <= 4'h0;
      end else if (quiet != 4'hf) begin
        quiet <= quiet + 4'h1;
      end
    end
  end
  // A read access phase at one address.
  sequence s_rd(logic [31:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  chk_ack_answer: assert property (
    cpu_ack |=> vector_valid) else $error("ack got no vector");
  chk_valid_cause: assert property (
    !cpu_ack |=> !vector_valid) else $error("vector without ack");
  chk_nmi_single: assert property (
    nmi_request |=> !nmi_request) else $error("nmi request too long");
  chk_nmi_cause: assert property (
    nmi_request |-> quiet <= 4'h6) else $error("nmi request without pin edge");
  chk_timer_rsvd: assert property (
    s_rd(`IVNC_ADDR_TIMER_VEC) |-> prdata[31:15] == 17'h0 && prdata[7:0] == 8'h00)
    else $error("timer vector reserved bits set");
  chk_wdt_rsvd: assert property (
    s_rd(`IVNC_ADDR_WDT_BCM_VEC) |-> prdata[31:15] == 17'h0 && !prdata[7])
    else $error("watchdog vector reserved bits set");
  chk_div_upper: assert property (
    s_rd(`IVNC_ADDR_DIV_VEC) |-> prdata[31:16] == 16'h0) else $error("divider upper set");
  chk_dma_upper: assert property (
    (s_rd(`IVNC_ADDR_DMA0_VEC) or s_rd(`IVNC_ADDR_DMA1_VEC)) |-> prdata[31:8] == 24'h0)
    else $error("dma vector upper set");
  chk_nmi_level: assert property (
    s_rd(`IVNC_ADDR_INT_CTRL) ##0 quiet >= 4'h4 |-> prdata[15] == nmi_pin)
    else $error("pin level bit wrong");
  chk_prio_shared: assert property (
    watchdog_priority == buscmp_priority) else $error("priorities differ");
endmodule
bind ivnc_top ivnc_props #(.NMI_SYNC_STAGES(NMI_SYNC_STAGES), .EXT_SYNC_STAGES(EXT_SYNC_STAGES))
  ivnc_props_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .nmi_pin,
  .cpu_ack, .vector_valid, .nmi_request, .watchdog_priority, .buscmp_priority);

// ==== tb/ivnc_far.sv ====
`timescale 1ns/10ps
// ************************************************************
// Event sources, pins and CPU acknowledge side.
// ************************************************************
module ivnc_far (
  // Clock.
  input wire logic pclk,
  // Answer from the block.
  input wire logic [15:0] vector_out,
  input wire logic vector_valid,
  // Towards the block.
  output logic [5:0] events,
  output logic nmi_pin,
  output logic [15:0] ext_vector,
  output logic cpu_ack,
  output logic [2:0] cpu_ack_src
);
  // Everything idle at time zero.
  initial begin
    events = 6'h00;
    nmi_pin = 1'b0;
    ext_vector = 16'h0000;
    cpu_ack = 1'b0;
    cpu_ack_src = 3'h0;
  end
  // One-cycle event pulse on source i.
  task automatic pulse(input int i);
    @(posedge pclk);
    events[i] <= 1'b1;
    @(posedge pclk);
    events <= 6'h00;
  endtask
  // Set the pin and the external vector lines.
  task automatic drive(input logic p, input logic [15:0] e);
    @(posedge pclk);
    nmi_pin <= p;
    ext_vector <= e;
  endtask
  // Acknowledge; the source id is inverted once released, which can still be a valid id (source 2 becomes 5).
  task automatic ack(input logic [2:0] src, output logic [15:0] vec);
    @(posedge pclk);
    cpu_ack <= 1'b1;
    cpu_ack_src <= src;
    @(posedge pclk);
    cpu_ack <= 1'b0;
    cpu_ack_src <= ~src;
    #1;
    vec = (vector_valid === 1'b1) ? vector_out : 16'hxxxx;
  endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`include "ivnc_params.svh"
// ************************************************************
// Self-checking bench for the vector and pin block.
// ************************************************************
module tb;
  // Bus, pin and request signals.
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic nmi_pin, cpu_ack, vector_valid, irq, nmi_request;
  logic [5:0] events;
  logic [15:0] ext_vector, vector_out, vec;
  logic [2:0] cpu_ack_src;
  logic [3:0] watchdog_priority, buscmp_priority;
  int err_count, checks_done, nmi_seen;
  localparam logic [15:0] EXTV = 16'hbeef;
  // One row: address, value written, value read back, error expected.
  typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] q; logic e;} ivnc_row_s;
  ivnc_row_s rows[8] = '{
    '{`IVNC_ADDR_TIMER_VEC, 32'h0000b3ff, 32'h00003300, 1'b0},
    '{`IVNC_ADDR_WDT_BCM_VEC, 32'hffffaa95, 32'h00002a15, 1'b0},
    '{`IVNC_ADDR_DIV_VEC, 32'hffffffff, 32'h0000ffff, 1'b0},
    '{`IVNC_ADDR_DMA0_VEC, 32'hffffffff, 32'h000000ff, 1'b0},
    '{`IVNC_ADDR_DMA1_VEC, 32'h000001a5, 32'h000000a5, 1'b0},
    '{`IVNC_ADDR_PRIORITY, 32'h000000a0, 32'h000000a0, 1'b0},
    '{`IVNC_ADDR_INT_CTRL, 32'h0000ffff, 32'h00000101, 1'b0},
    '{32'hffffff00, 32'h12345678, 32'h00000000, 1'b1}};
  // Vector expected for each source id after the rows are written.
  logic [15:0] vexp[7] = '{16'h0033, 16'h002a, 16'h0015, 16'hffff, 16'h00ff, 16'h00a5, 16'h0};
  ivnc_top ivnc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .timer_overflow_event(events[0]),
    .watchdog_interval_event(events[1]), .bus_compare_match_event(events[2]),
    .divider_fault_event(events[3]), .dma_end_event(events[5:4]), .nmi_pin, .ext_vector,
    .cpu_ack, .cpu_ack_src, .vector_out, .vector_valid, .irq, .nmi_request,
    .watchdog_priority, .buscmp_priority);
  ivnc_far ivnc_far_inst (.pclk, .vector_out, .vector_valid, .events, .nmi_pin,
    .ext_vector, .cpu_ack, .cpu_ack_src);
  // 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Count request pulses seen on the pin path.
  always @(posedge pclk) begin
    if (nmi_request === 1'b1) begin
      nmi_seen++;
    end
  end
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // The wait ends once pready is seen high; the watchdog ends it otherwise.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Count a comparison and report a mismatch.
  task automatic check(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  // Move the pin, then count request pulses over a settled span.
  task automatic nmi_step(input logic p, input int want);
    ivnc_far_inst.drive(p, EXTV);
    nmi_seen = 0;
    repeat (8) @(posedge pclk);
    check(nmi_seen == want, "nmi request count");
  endtask
  // Verdict and end of run.
  task automatic end_of_test();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Cut a hang short; the run needs well under a tenth of this.
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn, err_count, checks_done} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    ivnc_far_inst.drive(1'b0, EXTV);
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      check(rd === 32'h0 && er === rows[i].e, "reset value");
      apb(1'b1, rows[i].a, rows[i].d);
      check(er === rows[i].e, "write error");
      apb(1'b0, rows[i].a, 32'h0);
      check(rd === rows[i].q && er === rows[i].e, "read back");
    end
    check(watchdog_priority === 4'ha && buscmp_priority === 4'ha, "priority");
    // The control row left external mode on.
    ivnc_far_inst.ack(3'h2, vec);
    check(vec === EXTV, "external vector");
    apb(1'b1, `IVNC_ADDR_INT_CTRL, 32'h0);
    for (int s = 0; s < 7; s++) begin
      ivnc_far_inst.ack(3'(s), vec);
      check(vec === vexp[s], "auto vector");
    end
    // Sticky status, mask and the level interrupt.
    apb(1'b1, `IVNC_ADDR_INT_MASK, 32'h0);
    for (int s = 0; s < 6; s++) begin
      ivnc_far_inst.pulse(s);
    end
    apb(1'b0, `IVNC_ADDR_INT_STATUS, 32'h0);
    check(rd === 32'h3f && irq === 1'b0, "status while masked");
    apb(1'b1, `IVNC_ADDR_INT_MASK, 32'h4);
    repeat (2) @(posedge pclk);
    check(irq === 1'b1, "irq unmasked");
    apb(1'b1, `IVNC_ADDR_INT_STATUS, 32'h3f);
    repeat (2) @(posedge pclk);
    check(irq === 1'b0, "irq after clear");
    // Falling edge is the default selection; then rising.
    nmi_step(1'b1, 0);
    apb(1'b0, `IVNC_ADDR_INT_CTRL, 32'h0);
    check(rd === 32'h00008000, "pin level high");
    nmi_step(1'b0, 1);
    apb(1'b1, `IVNC_ADDR_INT_CTRL, 32'h100);
    nmi_step(1'b1, 1);
    nmi_step(1'b0, 0);
    // Status holds 0x40 from the pin edges; an event in its clear cycle must win.
    fork
      apb(1'b1, `IVNC_ADDR_INT_STATUS, 32'h7f);
      begin
        @(posedge pclk);
        ivnc_far_inst.pulse(0);
      end
    join
    apb(1'b0, `IVNC_ADDR_INT_STATUS, 32'h0);
    check(rd === 32'h1, "set beats clear");
    // Reset again in mid-run; priority, control and divider must fall back to their defaults.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check(watchdog_priority === 4'h0 && buscmp_priority === 4'h0, "prio reset");
    apb(1'b0, `IVNC_ADDR_INT_CTRL, 32'h0);
    check(rd === 32'h0, "control after reset");
    apb(1'b0, `IVNC_ADDR_DIV_VEC, 32'h0);
    check(rd === 32'h0, "divider after reset");
    end_of_test();
  end
endmodule
